//--- rtl/scc_pkg.sv
/*
  scc_pkg: shared constants for the stepper chopper and current block.
  Assumes a 200 MHz system clock; the parameter numbers are those used on
  the command interface.
*/
package scc_pkg;

  // ----------------------------------------------------------------------
  // parameter numbers on the command interface
  // ----------------------------------------------------------------------
  localparam logic [7:0] PN_RAMP_TIME    = 8'h1f;
  localparam logic [7:0] PN_DWELL_WIDTH  = 8'h20;
  localparam logic [7:0] PN_DWELL_SENS   = 8'h21;
  localparam logic [7:0] PN_REL_BASE     = 8'h7f;
  localparam logic [7:0] PN_USTEP        = 8'h8c;
  localparam logic [7:0] PN_BLANK        = 8'ha2;
  localparam logic [7:0] PN_CTO_MODE     = 8'ha3;
  localparam logic [7:0] PN_FD_CMP_OFF   = 8'ha4;
  localparam logic [7:0] PN_HYST_END     = 8'ha5;
  localparam logic [7:0] PN_HYST_START   = 8'ha6;
  localparam logic [7:0] PN_OFF_TIME     = 8'ha7;
  localparam logic [7:0] PN_CUR_FLOOR    = 8'ha8;
  localparam logic [7:0] PN_DEC_RATE     = 8'ha9;
  localparam logic [7:0] PN_LOAD_HYST    = 8'haa;
  localparam logic [7:0] PN_INC_SIZE     = 8'hab;
  localparam logic [7:0] PN_LOAD_LOWER   = 8'hac;
  localparam logic [7:0] PN_ACT_SCALE    = 8'hb4;

  // ----------------------------------------------------------------------
  // field limits and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] USTEP_MAX       = 4'h8;
  localparam logic [3:0] HSTART_MAX      = 4'h8;
  localparam logic [1:0] REL_BASE_MAX    = 2'h2;
  localparam logic [3:0] USTEP_RST       = 4'h8;
  localparam logic [1:0] BLANK_RST       = 2'h2;
  localparam logic [4:0] SCALE_FULL      = 5'h1f;

  // relative move base codes
  localparam logic [1:0] REL_PREV_TARGET = 2'h0;
  localparam logic [1:0] REL_ACTUAL      = 2'h1;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 5;
  localparam int RAMP_UNIT_NS    = 163840000;  // 0.16384 s per ramp unit
  localparam int RAMP_UNIT_CYC   = RAMP_UNIT_NS / CLK_PERIOD_NS;
  localparam int RAMP_LEVELS     = 32;
  localparam logic [9:0] OFF_BASE      = 10'h00c;  // 12 clocks
  localparam logic [9:0] OFF_MIN       = 10'h040;  // 64 clocks
  localparam int OFF_SHIFT       = 5;              // times 32
  localparam int FAST_SHIFT      = 5;              // fast decay unit 32 clocks
  localparam int LOAD_SHIFT      = 5;              // thresholds times 32
  // blanking lengths in clocks per 2-bit code
  localparam logic [9:0] BLANK_CYC [4] = '{10'h010, 10'h018, 10'h024, 10'h036};

  typedef enum logic [1:0] {SCC_IDLE, SCC_ON, SCC_FAST, SCC_OFF} scc_chop_t;

endpackage

//--- rtl/scc_chopper_current.sv
/*
  scc_chopper_current: command-set parameters, standstill power-down ramp,
  constant-dwell load check, relative target, microstep decode, chopper
  sequencer and load-adaptive current scale.
  Assumes all inputs are synchronous to clock and the command port is
  driven by a single host issuing one access at a time.
*/
// Functional notes
// - standstill ramp: 4-bit field, 0.16384 s units
// - ramp starts after rest plus settling delay
// - 10-bit reference pulse width for dwell load
// - stall sensitivity 0..255, higher is more sensitive
// - relative move base: target, actual, encoder
// - microsteps per full step is two to code
// - comparator masked for coded blanking interval
// - mode bit: 0 hysteresis, 1 constant off-time
// - comparator-disable ends fast decay by time only
// - shared field: hysteresis end or fast decay
// - shared field: hysteresis start or sine offset
// - off phase 12 plus 32 times setting, min 64
// - off-time zero disables every bridge transistor
// - current floor half or quarter of run scale
// - decrement after 32, 8, 2 or 1 high readings
// - upper threshold is (lower plus hysteresis plus one) times 32
// - increment by 1, 2, 4 or 8 per low reading
// - lower load threshold from own 4-bit setting
// - adaptive scale kept between floor and run scale
`timescale 1ns/100ps
`default_nettype none

module scc_chopper_current #(
  parameter logic [31:0] RAMP_STEP_CYCLES = 32'(scc_pkg::RAMP_UNIT_CYC / scc_pkg::RAMP_LEVELS),
  parameter logic [15:0] SETTLE_CYCLES    = 16'h1000
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // command port
  input  wire logic                 param_wr,
  input  wire logic                 param_rd,
  input  wire logic [7:0]           param_num,
  input  wire logic [31:0]          param_wdata,
  output logic      [31:0]          param_rdata,
  output logic                      param_ack,
  output logic                      param_err,
  // motion status and standstill current
  input  wire logic                 motor_standstill,
  input  wire logic [4:0]           hold_scale,
  output logic      [4:0]           standstill_level,
  // constant-dwell load check
  input  wire logic                 dwell_mode,
  input  wire logic                 step_pulse,
  output logic                      dwell_stall,
  // relative move
  input  wire logic                 relative_move_command,
  input  wire logic [31:0]          rel_distance,
  input  wire logic [31:0]          actual_position,
  input  wire logic [31:0]          encoder_position,
  output logic      [31:0]          move_target,
  output logic                      move_target_valid,
  // microstep and chopper
  output logic      [8:0]           microsteps_per_full,
  input  wire logic                 current_above,
  output logic                      bridge_enable,
  output logic                      bridge_fast_decay,
  output logic                      bridge_slow_decay,
  output logic                      comparator_masked,
  output logic      [4:0]           hysteresis_level,
  output logic      [3:0]           sine_offset,
  // adaptive current
  input  wire logic [4:0]           run_current_scale,
  input  wire logic                 load_valid,
  input  wire logic [9:0]           load_value,
  output logic      [4:0]           actual_current_scale
);
  import scc_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // off phase length, clamped to the minimum
  function automatic logic [9:0] off_cycles(input logic [3:0] t);
    logic [9:0] n;
    n = OFF_BASE + (10'(t) << OFF_SHIFT);
    return (n < OFF_MIN) ? OFF_MIN : n;
  endfunction

  // lower end of the adaptive range
  function automatic logic [4:0] scale_floor(input logic [4:0] run, input logic sel);
    return sel ? (run >> 2) : (run >> 1);
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  ramp_time;
    logic [9:0]  dwell_width;
    logic [7:0]  dwell_sens;
    logic [1:0]  rel_base;
    logic [3:0]  ustep;
    logic [1:0]  blank;
    logic        cto_mode;
    logic        fd_cmp_off;
    logic [3:0]  hyst_end;
    logic [3:0]  hyst_start;
    logic [3:0]  chopper_off_time;
    logic        cur_floor;
    logic [1:0]  dec_rate;
    logic [3:0]  load_hyst;
    logic [1:0]  inc_size;
    logic [3:0]  load_lower;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
    logic [15:0] settle_cnt;
    logic [31:0] ramp_cnt;
    logic [4:0]  pd_level;
    scc_chop_t   chop;
    logic [9:0]  chop_cnt;
    logic [15:0] dw_cnt;
    logic [7:0]  dw_over;
    logic        stall;
    logic [4:0]  act_scale;
    logic [5:0]  dec_cnt;
    logic [31:0] target;
    logic        target_vld;
  } scc_state_t;

  scc_state_t s_reg;
  scc_state_t s_next;

  // derived decodes shared by logic and checks
  logic [9:0] blank_len;
  logic [9:0] off_len;
  logic [9:0] fast_len;
  logic [9:0] lower_thr;
  logic [9:0] upper_thr;
  logic [4:0] floor_scale;
  logic [5:0] dec_need;
  logic [4:0] inc_step;
  logic [31:0] ramp_interval;

  // ----------------------------------------------------------------------
  // decodes of the stored settings
  // ----------------------------------------------------------------------
  assign blank_len     = BLANK_CYC[s_reg.blank];
  assign off_len       = off_cycles(s_reg.chopper_off_time);
  assign fast_len      = 10'(s_reg.hyst_end) << FAST_SHIFT;
  assign lower_thr     = 10'(s_reg.load_lower) << LOAD_SHIFT;
  assign upper_thr     = (10'(s_reg.load_lower) + 10'(s_reg.load_hyst) + 10'h001)
                         << LOAD_SHIFT;
  assign floor_scale   = scale_floor(run_current_scale, s_reg.cur_floor);
  assign dec_need      = (&s_reg.dec_rate) ? 6'h01 : 6'h20 >> {s_reg.dec_rate, 1'b0};
  assign inc_step      = 5'h01 << s_reg.inc_size;
  assign ramp_interval = 32'(s_reg.ramp_time) * RAMP_STEP_CYCLES;

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [5:0] up_sum;
    logic [31:0] base;
    up_sum = 6'h00;
    base   = 32'h0;
    s_next = s_reg;
    s_next.ack        = 1'b0;
    s_next.err        = 1'b0;
    s_next.target_vld = 1'b0;

    // command port; out-of-range rel_base, ustep and hyst_start writes are refused and leave the field; other fields keep the low bits
    if (param_wr) begin
      s_next.ack = 1'b1;
      unique case (param_num)
        PN_RAMP_TIME:   s_next.ramp_time   = param_wdata[3:0];
        PN_DWELL_WIDTH: s_next.dwell_width = param_wdata[9:0];
        PN_DWELL_SENS:  s_next.dwell_sens  = param_wdata[7:0];
        PN_REL_BASE: begin
          if (param_wdata[1:0] > REL_BASE_MAX || param_wdata[31:2] != '0) s_next.err = 1'b1;
          else s_next.rel_base = param_wdata[1:0];
        end
        PN_USTEP: begin
          if (param_wdata[3:0] > USTEP_MAX || param_wdata[31:4] != '0) s_next.err = 1'b1;
          else s_next.ustep = param_wdata[3:0];
        end
        PN_BLANK:       s_next.blank       = param_wdata[1:0];
        PN_CTO_MODE:    s_next.cto_mode    = param_wdata[0];
        PN_FD_CMP_OFF:  s_next.fd_cmp_off  = param_wdata[0];
        PN_HYST_END:    s_next.hyst_end    = param_wdata[3:0];
        PN_HYST_START: begin
          if (param_wdata[3:0] > HSTART_MAX || param_wdata[31:4] != '0) s_next.err = 1'b1;
          else s_next.hyst_start = param_wdata[3:0];
        end
        PN_OFF_TIME:    s_next.chopper_off_time        = param_wdata[3:0];
        PN_CUR_FLOOR:   s_next.cur_floor   = param_wdata[0];
        PN_DEC_RATE:    s_next.dec_rate    = param_wdata[1:0];
        PN_LOAD_HYST:   s_next.load_hyst   = param_wdata[3:0];
        PN_INC_SIZE:    s_next.inc_size    = param_wdata[1:0];
        PN_LOAD_LOWER:  s_next.load_lower  = param_wdata[3:0];
        default:        s_next.err         = 1'b1;  // unknown or read-only
      endcase
    end else if (param_rd) begin
      s_next.ack   = 1'b1;
      s_next.rdata = 32'h0;
      unique case (param_num)
        PN_RAMP_TIME:   s_next.rdata[3:0] = s_reg.ramp_time;
        PN_DWELL_WIDTH: s_next.rdata[9:0] = s_reg.dwell_width;
        PN_DWELL_SENS:  s_next.rdata[7:0] = s_reg.dwell_sens;
        PN_REL_BASE:    s_next.rdata[1:0] = s_reg.rel_base;
        PN_USTEP:       s_next.rdata[3:0] = s_reg.ustep;
        PN_BLANK:       s_next.rdata[1:0] = s_reg.blank;
        PN_CTO_MODE:    s_next.rdata[0]   = s_reg.cto_mode;
        PN_FD_CMP_OFF:  s_next.rdata[0]   = s_reg.fd_cmp_off;
        PN_HYST_END:    s_next.rdata[3:0] = s_reg.hyst_end;
        PN_HYST_START:  s_next.rdata[3:0] = s_reg.hyst_start;
        PN_OFF_TIME:    s_next.rdata[3:0] = s_reg.chopper_off_time;
        PN_CUR_FLOOR:   s_next.rdata[0]   = s_reg.cur_floor;
        PN_DEC_RATE:    s_next.rdata[1:0] = s_reg.dec_rate;
        PN_LOAD_HYST:   s_next.rdata[3:0] = s_reg.load_hyst;
        PN_INC_SIZE:    s_next.rdata[1:0] = s_reg.inc_size;
        PN_LOAD_LOWER:  s_next.rdata[3:0] = s_reg.load_lower;
        PN_ACT_SCALE:   s_next.rdata[4:0] = s_reg.act_scale;
        default:        s_next.err        = 1'b1;
      endcase
    end

    // standstill ramp; any motion restores full level at once
    if (!motor_standstill) begin
      s_next.settle_cnt = 16'h0;
      s_next.ramp_cnt   = 32'h0;
      s_next.pd_level   = SCALE_FULL;
    end else if (s_reg.settle_cnt < SETTLE_CYCLES) begin
      s_next.settle_cnt = s_reg.settle_cnt + 16'h1;
    end else if (s_reg.pd_level > hold_scale) begin
      if (s_reg.ramp_time == 4'h0) begin
        s_next.pd_level = hold_scale;
      end else if (s_reg.ramp_cnt >= ramp_interval - 32'h1) begin
        s_next.ramp_cnt = 32'h0;
        s_next.pd_level = s_reg.pd_level - 5'h1;
      end else begin
        s_next.ramp_cnt = s_reg.ramp_cnt + 32'h1;
      end
    end

    // dwell load check: a step period longer than the reference is a
    // heavy-load reading; enough in a row flags a stall
    if (!dwell_mode) begin
      s_next.dw_cnt  = 16'h0;
      s_next.dw_over = 8'h0;
    end else if (step_pulse) begin
      s_next.dw_cnt = 16'h0;
      if (s_reg.dw_cnt > 16'(s_reg.dwell_width)) begin
        if (s_reg.dw_over != 8'hff) s_next.dw_over = s_reg.dw_over + 8'h1;
      end else begin
        s_next.dw_over = 8'h0;
      end
    end else if (s_reg.dw_cnt != 16'hffff) begin
      s_next.dw_cnt = s_reg.dw_cnt + 16'h1;
    end
    s_next.stall = dwell_mode && (s_reg.dwell_sens != 8'h0)
                   && (s_reg.dw_over > (8'hff - s_reg.dwell_sens));

    // relative target from the selected base
    if (relative_move_command) begin
      unique case (s_reg.rel_base)
        REL_PREV_TARGET: base = s_reg.target;
        REL_ACTUAL:      base = actual_position;
        default:         base = encoder_position;
      endcase
      s_next.target     = base + rel_distance;
      s_next.target_vld = 1'b1;
    end

    // chopper sequencer
    unique case (s_reg.chop)
      SCC_IDLE: begin
        s_next.chop_cnt = 10'h0;
        if (s_reg.chopper_off_time != 4'h0) s_next.chop = SCC_ON;
      end
      SCC_ON: begin
        if (s_reg.chop_cnt < blank_len) s_next.chop_cnt = s_reg.chop_cnt + 10'h1;
        if (s_reg.chop_cnt >= blank_len && current_above) begin
          s_next.chop_cnt = 10'h0;
          if (s_reg.cto_mode && s_reg.hyst_end != 4'h0) s_next.chop = SCC_FAST;
          else s_next.chop = SCC_OFF;
        end
      end
      SCC_FAST: begin
        s_next.chop_cnt = s_reg.chop_cnt + 10'h1;
        if (s_reg.chop_cnt >= fast_len - 10'h1
            || (!s_reg.fd_cmp_off && !current_above)) begin
          s_next.chop_cnt = 10'h0;
          s_next.chop     = SCC_OFF;
        end
      end
      SCC_OFF: begin
        s_next.chop_cnt = s_reg.chop_cnt + 10'h1;
        if (s_reg.chop_cnt >= off_len - 10'h1) begin
          s_next.chop_cnt = 10'h0;
          s_next.chop     = SCC_ON;
        end
      end
    endcase
    if (s_reg.chopper_off_time == 4'h0) begin
      s_next.chop     = SCC_IDLE;
      s_next.chop_cnt = 10'h0;
    end

    // adaptive current scale
    if (load_valid) begin
      if (load_value < lower_thr) begin
        up_sum         = 6'(s_reg.act_scale) + 6'(inc_step);
        s_next.act_scale = (up_sum > 6'(run_current_scale)) ? run_current_scale
                                                             : up_sum[4:0];
        s_next.dec_cnt = 6'h0;
      end else if (load_value > upper_thr) begin
        if (s_reg.dec_cnt + 6'h1 >= dec_need) begin
          s_next.dec_cnt   = 6'h0;
          s_next.act_scale = (s_reg.act_scale > floor_scale) ? s_reg.act_scale - 5'h1
                                                             : floor_scale;
        end else begin
          s_next.dec_cnt = s_reg.dec_cnt + 6'h1;
        end
      end
    end
    // the run scale may move under us; keep within range every cycle
    if (s_next.act_scale > run_current_scale) s_next.act_scale = run_current_scale;
    if (s_next.act_scale < floor_scale) s_next.act_scale = floor_scale;

    if (sys_rst) begin
      s_next            = '0;
      s_next.ustep      = USTEP_RST;
      s_next.blank      = BLANK_RST;
      s_next.pd_level   = SCALE_FULL;
      s_next.act_scale  = SCALE_FULL;
      s_next.chop       = SCC_IDLE;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign param_rdata          = s_reg.rdata;
  assign param_ack            = s_reg.ack;
  assign param_err            = s_reg.err;
  assign standstill_level     = s_reg.pd_level;
  assign dwell_stall          = s_reg.stall;
  assign move_target          = s_reg.target;
  assign move_target_valid    = s_reg.target_vld;
  assign microsteps_per_full  = 9'h001 << s_reg.ustep;
  // with off-time zero the sequencer is idle and every transistor is off
  assign bridge_enable        = (s_reg.chop != SCC_IDLE);
  assign bridge_fast_decay    = (s_reg.chop == SCC_FAST);
  assign bridge_slow_decay    = (s_reg.chop == SCC_OFF);
  assign comparator_masked    = (s_reg.chop != SCC_ON) || (s_reg.chop_cnt < blank_len);
  // hysteresis start is an offset on top of the end value
  assign hysteresis_level     = s_reg.cto_mode ? 5'h00
                                : 5'(s_reg.hyst_end) + 5'(s_reg.hyst_start);
  assign sine_offset          = s_reg.cto_mode ? s_reg.hyst_start : 4'h0;
  assign actual_current_scale = s_reg.act_scale;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_off_free_wheel: assert property (s_reg.chopper_off_time == 4'h0 |=> !bridge_enable)
    else $error("bridge active with off-time zero");
  a_off_phase_len: assert property (
    s_reg.chop == SCC_OFF && s_reg.chop_cnt < off_len - 10'h1 && s_reg.chopper_off_time != 4'h0
    && !param_wr |=> s_reg.chop == SCC_OFF)
    else $error("off phase ended early");
  a_off_min_len: assert property (off_len >= OFF_MIN)
    else $error("off phase below minimum");
  a_blank_masked: assert property (
    s_reg.chop == SCC_ON && s_reg.chop_cnt < blank_len |-> comparator_masked
    ##1 (s_reg.chop != SCC_FAST && s_reg.chop != SCC_OFF || $past(s_reg.chopper_off_time) == 4'h0))
    else $error("comparator used inside blanking");
  a_pd_after_settle: assert property (
    motor_standstill && s_reg.pd_level != SCALE_FULL |-> s_reg.settle_cnt == SETTLE_CYCLES)
    else $error("power-down ramp before settling");
  a_scale_range: assert property (
    $stable(run_current_scale) |=> actual_current_scale <= $past(run_current_scale)
    && actual_current_scale >= $past(floor_scale))
    else $error("current scale out of range");
  a_rel_target: assert property (
    relative_move_command && s_reg.rel_base == REL_ACTUAL |=>
    move_target_valid && move_target == $past(actual_position) + $past(rel_distance))
    else $error("relative target wrong");
  a_cmd_ack: assert property (
    param_wr && param_num == PN_OFF_TIME ##1 !param_wr && !param_rd |-> param_ack ##1 !param_ack)
    else $error("command not acknowledged once");
  a_ustep_decode: assert property (
    param_wr && param_num == PN_USTEP && param_wdata == 32'h2 |=> microsteps_per_full == 9'h004)
    else $error("microstep decode wrong");

endmodule

`default_nettype wire

//--- bench/scc_bridge_model.sv
/*
  scc_bridge_model: motor bridge and sense path as seen by the chopper.
  Assumes one clock; winding current builds only while the bridge drives on.
*/
`timescale 1ns/100ps
`default_nettype none
module scc_bridge_model #(
  parameter int RISE_CYC = 60
) (
  // clock
  input  wire logic clock,
  // bridge phases
  input  wire logic bridge_enable,
  input  wire logic bridge_fast_decay,
  input  wire logic bridge_slow_decay,
  // sense comparator
  output logic      current_above
);
  int on_cnt = 0;
  // current collapses in any decay or idle phase
  always @(posedge clock) begin
    if (bridge_enable && !bridge_fast_decay && !bridge_slow_decay) on_cnt <= on_cnt + 1;
    else on_cnt <= 0;
  end
  assign current_above = (on_cnt >= RISE_CYC); // beyond the longest blanking
endmodule
`default_nettype wire

//--- bench/test_scc_chopper_current.sv
/*
  test_scc_chopper_current: self-checking bench for scc_chopper_current.
  Assumes the bridge model feeds the sense comparator; inputs move at the
  falling edge and outputs are read at a later falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module test_scc_chopper_current;
  import scc_pkg::*;
  logic        clock = 0, sys_rst = 1, param_wr = 0, param_rd = 0, param_ack, param_err;
  logic [7:0]  param_num = 8'h00;
  logic [31:0] param_wdata = 0, param_rdata, move_target, rel_distance = 32'h5;
  logic [31:0] actual_position = 32'h100, encoder_position = 32'h1000;
  logic        relative_move_command = 0, load_valid = 0, move_target_valid, dwell_stall;
  logic        motor_standstill = 0, dwell_mode = 0, step_pulse = 0, sel_fast = 0;
  logic        current_above, bridge_enable, bridge_fast_decay, bridge_slow_decay;
  logic        comparator_masked;
  wire logic   phase_on = sel_fast ? bridge_fast_decay : bridge_slow_decay;
  logic [4:0]  standstill_level, hysteresis_level, actual_current_scale;
  logic [4:0]  run_current_scale = 5'h1f, hold_scale = 5'h1c;
  logic [3:0]  sine_offset;
  logic [8:0]  microsteps_per_full;
  logic [9:0]  load_value = 10'h000;
  logic [7:0]  nums [16] = '{8'h1f, 8'h20, 8'h21, 8'h7f, 8'h8c, 8'ha2, 8'ha3, 8'ha4,
                             8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac};
  logic [9:0]  vals [16] = '{10'h00f, 10'h3ff, 10'h0ff, 10'h002, 10'h005, 10'h003, 10'h001,
                             10'h001, 10'h00f, 10'h008, 10'h00f, 10'h001, 10'h003, 10'h00f,
                             10'h003, 10'h00f};
  int          fails = 0, check_count = 0, cyc = 0, n;

  scc_chopper_current #(.RAMP_STEP_CYCLES(32'h4), .SETTLE_CYCLES(16'h8)) scc_chopper_current_i (
    .clock, .sys_rst, .param_wr, .param_rd, .param_num, .param_wdata, .param_rdata,
    .param_ack, .param_err, .motor_standstill, .hold_scale, .standstill_level,
    .dwell_mode, .step_pulse, .dwell_stall, .relative_move_command, .rel_distance,
    .actual_position, .encoder_position, .move_target, .move_target_valid, .microsteps_per_full,
    .current_above, .bridge_enable, .bridge_fast_decay, .bridge_slow_decay, .comparator_masked,
    .hysteresis_level, .sine_offset, .run_current_scale, .load_valid, .load_value,
    .actual_current_scale);
  scc_bridge_model scc_bridge_model_i (.clock, .bridge_enable, .bridge_fast_decay,
    .bridge_slow_decay, .current_above);

  // clock and hang guard; whole run needs under two thousand cycles
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one access, strobe held one edge, answer seen after that edge
  task automatic acc(input logic wr, input logic [7:0] num, input logic [31:0] v,
                     input logic err, output logic [31:0] rd);
    @(negedge clock);
    param_wr = wr;
    param_rd = !wr;
    param_num = num;
    param_wdata = v;
    @(negedge clock);
    param_wr = 0;
    param_rd = 0;
    chk("ack", 1, param_ack);
    chk("err", err, param_err);
    rd = param_rdata;
  endtask
  task automatic wrp(input logic [7:0] num, input logic [31:0] v, input logic err);
    logic [31:0] r;
    acc(1, num, v, err, r);
  endtask
  task automatic rdc(input logic [7:0] num, input logic [31:0] exp);
    logic [31:0] r;
    acc(0, num, 0, 0, r);
    chk("rdata", exp, r);
  endtask
  task automatic t_reset;
    rdc(PN_USTEP, 8);
    rdc(PN_BLANK, 2);
    rdc(PN_OFF_TIME, 0);
    chk("usteps", 256, microsteps_per_full);
    chk("bridge", 0, bridge_enable);
    chk("masked", 1, comparator_masked);
    chk("scale", 31, actual_current_scale);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 16; i++) begin
      wrp(nums[i], 32'(vals[i]), 0);
      rdc(nums[i], 32'(vals[i]));
    end
    chk("usteps", 32, microsteps_per_full);
    chk("offset", 8, sine_offset);
    chk("hyst", 0, hysteresis_level);
    wrp(PN_USTEP, 9, 1);
    wrp(PN_HYST_START, 9, 1);
    wrp(PN_REL_BASE, 3, 1);
    wrp(PN_ACT_SCALE, 0, 1);
    wrp(8'h00, 0, 1);
    rdc(PN_USTEP, 5);
  endtask
  task automatic mv(input logic [1:0] base, input logic [31:0] exp);
    wrp(PN_REL_BASE, 32'(base), 0);
    @(negedge clock);
    relative_move_command = 1;
    @(negedge clock);
    relative_move_command = 0;
    chk("valid", 1, move_target_valid);
    chk("target", exp, move_target);
  endtask
  // skip to a fresh off or fast phase so the new setting is in force, then time it
  task automatic offlen(input logic fd, input logic [3:0] t, input int exp);
    sel_fast = fd;
    wrp(PN_OFF_TIME, 32'(t), 0);
    repeat (150) @(negedge clock);
    for (n = 0; phase_on === 1'b1 && n < 300; n++) @(negedge clock);
    for (n = 0; phase_on !== 1'b1 && n < 300; n++) @(negedge clock);
    for (n = 0; phase_on === 1'b1 && n < 300; n++) @(negedge clock);
    chk("phase_len", exp, n);
  endtask
  task automatic t_chop;
    wrp(PN_CTO_MODE, 0, 0);
    wrp(PN_HYST_END, 3, 0);
    wrp(PN_HYST_START, 2, 0);
    chk("hyst", 5, hysteresis_level);
    chk("offset", 0, sine_offset);
    offlen(0, 1, 64);
    offlen(0, 2, 76);
    // constant off-time: fast phase 32 clocks by time, or cut by the comparator
    wrp(PN_CTO_MODE, 1, 0);
    wrp(PN_HYST_END, 1, 0);
    offlen(1, 2, 32);
    wrp(PN_FD_CMP_OFF, 0, 0);
    offlen(1, 2, 2);
    wrp(PN_OFF_TIME, 0, 0);
    repeat (3) @(negedge clock);
    chk("phases", 0, {bridge_enable, bridge_fast_decay, bridge_slow_decay});
  endtask
  task automatic ld(input logic [9:0] v, input int k, input logic [4:0] exp);
    repeat (k) begin
      @(negedge clock);
      load_valid = 1;
      load_value = v;
      @(negedge clock);
      load_valid = 0;
    end
    repeat (2) @(negedge clock);
    chk("scale", exp, actual_current_scale);
  endtask
  // lower threshold 64, upper (2+1+1)*32 = 128
  task automatic t_adapt;
    wrp(PN_LOAD_LOWER, 2, 0);
    wrp(PN_LOAD_HYST, 1, 0);
    wrp(PN_CUR_FLOOR, 0, 0);
    wrp(PN_DEC_RATE, 3, 0);
    run_current_scale = 5'h08;
    ld(10'h080, 1, 8);
    ld(10'h081, 10, 4);
    wrp(PN_CUR_FLOOR, 1, 0);
    ld(10'h081, 10, 2);
    wrp(PN_INC_SIZE, 2, 0);
    ld(10'h03f, 1, 6);
    ld(10'h040, 1, 6);
    wrp(PN_INC_SIZE, 3, 0);
    ld(10'h000, 1, 8);
    wrp(PN_DEC_RATE, 1, 0);
    ld(10'h081, 7, 8);
    ld(10'h081, 1, 7);
  endtask
  // settle 8 edges, then one level down per 4 edges at ramp time 1
  task automatic t_ramp;
    wrp(PN_RAMP_TIME, 1, 0);
    motor_standstill = 1;
    repeat (11) @(negedge clock);
    chk("level", 31, standstill_level);
    @(negedge clock);
    chk("level", 30, standstill_level);
    repeat (10) @(negedge clock);
    chk("level", 28, standstill_level);
    motor_standstill = 0;
    @(negedge clock);
    chk("level", 31, standstill_level);
  endtask
  task automatic dw(input int gap, input int k, input logic exp);
    repeat (k) begin
      @(negedge clock);
      step_pulse = 1;
      @(negedge clock);
      step_pulse = 0;
      repeat (gap) @(negedge clock);
    end
    chk("stall", exp, dwell_stall);
  endtask
  // width 4: a gap of 6 overruns; at 254 two overruns in a row stall
  task automatic t_dwell;
    wrp(PN_DWELL_WIDTH, 4, 0);
    wrp(PN_DWELL_SENS, 8'hfe, 0);
    dwell_mode = 1;
    dw(6, 2, 0);
    dw(6, 1, 1);
    dw(2, 2, 0);
    dwell_mode = 0;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clock);
    sys_rst = 0;
    t_reset;
    t_regs;
    mv(1, 32'h105);
    mv(0, 32'h10a);
    mv(2, 32'h1005);
    t_chop;
    t_adapt;
    t_ramp;
    t_dwell;
    end_of_test;
  end
endmodule
`default_nettype wire
